// >>> design/aexu_byte_alu.sv
// aexu_byte_alu: 8-bit add / subtract with carry-in and flag terms
// assumes: purely combinational, flags merged by the caller

`timescale 1ns/10ps
`default_nettype none

module aexu_byte_alu (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic is_sub,
  // result
  output logic [7:0] res,
  output logic half,
  output logic ovf,
  output logic carry
);

  logic [8:0] sum;

  // sum or difference, carry-in added or borrowed
  assign sum = is_sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                      : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
  assign res = sum[7:0];

  // carry or borrow into bit 4, overflow from the operand and result signs
  assign half = a[4] ^ b[4] ^ res[4];
  assign ovf = is_sub ? ((a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]))
                      : ((a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]));
  assign carry = sum[8];

endmodule : aexu_byte_alu

`default_nettype wire

// >>> design/aexu_exec.sv
// aexu_exec: execution of arithmetic, logic, compare, skip, branch and
// single i/o bit instructions, with status flags and program counter
// assumes: decoded instruction and register values come from logic on clk;
// the register file, stack and i/o registers live outside this block
//
// How it works
// - add with or without carry, one cycle, sets z c n v h
// - subtract register or constant, optional carry, one cycle, z c n v h
// - word add or subtract immediate, two cycles, sets z c n v s
// - and, or, exclusive or, one cycle, only z n v change
// - set bits ors the mask, clear bits ands with ff minus mask
// - test ands register with itself, value kept, sets z n v
// - compares subtract without storing, one cycle, sets z n v c h
// - indirect jump loads pc from z pointer in two cycles
// - indirect call loads pc from z pointer in three cycles
// - compare skip equal skips next instruction, one two or three cycles
// - skip on register bit clear or set, no flags changed
// - skip on i/o bit clear or set, one two or three cycles
// - branch on flag adds offset plus one, one or two cycles
// - bit access instructions reach only i/o addresses up to 1f
// - bit set and clear touch only the addressed i/o bit
// - some peripheral flags clear when a one is written there
// - setting or clearing an i/o bit takes two cycles, no flags

`timescale 1ns/10ps
`default_nettype none

module aexu_exec (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction handshake
  input wire logic instr_valid,
  input wire aexu_pkg::aexu_instr_t instr,
  output logic instr_ready,
  output logic done,
  output logic illegal,
  // i/o bit read, same clock
  output logic [4:0] io_rd_addr,
  input wire logic [7:0] io_rd_data,
  // results
  output aexu_pkg::aexu_wb_t wb,
  output aexu_pkg::aexu_io_wr_t io_wr,
  output logic push_en,
  output logic [15:0] push_addr,
  output logic [7:0] sreg,
  output logic [15:0] pc
);

  // --------
  // state
  // --------
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } aexu_state_t;

  aexu_state_t state;
  logic [1:0] count;
  logic take;

  // zero test on a byte, used for several flag paths
  function automatic logic is_zero8(input logic [7:0] v);
    is_zero8 = (v == 8'h00);
  endfunction : is_zero8

  // length of a skip from the size of the skipped instruction
  function automatic logic [1:0] skip_cycles(input logic two_word);
    skip_cycles = two_word ? aexu_pkg::CYC_SKIP_TWO_WORD
                           : aexu_pkg::CYC_SKIP_ONE_WORD;
  endfunction : skip_cycles

  // --------
  // operation classes
  // --------
  aexu_pkg::aexu_op_t op;
  logic use_carry;
  logic is_sub;
  logic use_imm;
  logic is_arith;
  logic is_compare;
  logic is_word;
  logic is_logic;
  logic is_io_bit;
  logic is_io_skip;
  logic io_addr_ok;

  // class decode from the operation code
  assign op = instr.op;
  assign use_carry = (op == aexu_pkg::op_add_carry)
    || (op == aexu_pkg::op_subtract_with_carry)
    || (op == aexu_pkg::op_subtract_immediate_with_carry)
    || (op == aexu_pkg::op_compare_with_carry);
  assign is_sub = !((op == aexu_pkg::op_add)
    || (op == aexu_pkg::op_add_carry));
  assign use_imm = (op == aexu_pkg::op_subtract_immediate)
    || (op == aexu_pkg::op_subtract_immediate_with_carry)
    || (op == aexu_pkg::op_compare_immediate);
  assign is_compare = (op == aexu_pkg::op_compare_registers)
    || (op == aexu_pkg::op_compare_with_carry)
    || (op == aexu_pkg::op_compare_immediate);
  assign is_arith = is_compare || (op == aexu_pkg::op_add)
    || (op == aexu_pkg::op_add_carry) || (op == aexu_pkg::op_subtract)
    || (op == aexu_pkg::op_subtract_immediate)
    || (op == aexu_pkg::op_subtract_with_carry)
    || (op == aexu_pkg::op_subtract_immediate_with_carry);
  assign is_word = (op == aexu_pkg::op_word_add_immediate)
    || (op == aexu_pkg::op_word_subtract_immediate);
  assign is_logic = (op == aexu_pkg::op_and)
    || (op == aexu_pkg::op_and_immediate) || (op == aexu_pkg::op_or)
    || (op == aexu_pkg::op_or_immediate)
    || (op == aexu_pkg::op_exclusive_or_registers)
    || (op == aexu_pkg::op_set_bits_mask)
    || (op == aexu_pkg::op_clear_bits_mask)
    || (op == aexu_pkg::op_test_zero_minus);
  assign is_io_bit = (op == aexu_pkg::op_set_io_bit)
    || (op == aexu_pkg::op_clear_io_bit);
  assign is_io_skip = (op == aexu_pkg::op_skip_io_bit_clear)
    || (op == aexu_pkg::op_skip_io_bit_set);
  // bit access limited to the low i/o range
  assign io_addr_ok = (instr.io_addr <= aexu_pkg::IO_BIT_ADDR_MAX);
  assign io_rd_addr = instr.io_addr[4:0];

  // --------
  // arithmetic units
  // --------
  logic [7:0] arith_b;
  logic [7:0] arith_res;
  logic arith_h;
  logic arith_v;
  logic arith_c;
  logic [15:0] word_res;
  logic word_v;
  logic word_c;

  // second operand is a register or a constant
  assign arith_b = use_imm ? instr.imm : instr.rr_val;

  aexu_byte_alu u_byte_alu (
    .a(instr.rd_val),
    .b(arith_b),
    .cin(use_carry & sreg[aexu_pkg::FLAG_C]),
    .is_sub(is_sub),
    .res(arith_res),
    .half(arith_h),
    .ovf(arith_v),
    .carry(arith_c)
  );

  aexu_word_alu u_word_alu (
    .w(instr.word_val),
    .k(instr.imm[5:0]),
    .is_sub(op == aexu_pkg::op_word_subtract_immediate),
    .res(word_res),
    .ovf(word_v),
    .carry(word_c)
  );

  // --------
  // logic unit
  // --------
  logic [7:0] logic_res;

  // mask ops and test reuse the and and or paths
  assign logic_res =
    (op == aexu_pkg::op_and) ? (instr.rd_val & instr.rr_val) :
    (op == aexu_pkg::op_and_immediate) ? (instr.rd_val & instr.imm) :
    (op == aexu_pkg::op_or) ? (instr.rd_val | instr.rr_val) :
    (op == aexu_pkg::op_or_immediate) ? (instr.rd_val | instr.imm) :
    (op == aexu_pkg::op_exclusive_or_registers) ?
      (instr.rd_val ^ instr.rr_val) :
    (op == aexu_pkg::op_set_bits_mask) ? (instr.rd_val | instr.imm) :
    (op == aexu_pkg::op_clear_bits_mask) ?
      (instr.rd_val & (aexu_pkg::BYTE_ALL_ONES - instr.imm)) :
    (instr.rd_val & instr.rd_val);

  // --------
  // skip and branch conditions
  // --------
  logic reg_bit;
  logic io_bit;
  logic flag_bit;
  logic skip_hit;
  logic branch_hit;
  logic [15:0] branch_offset;

  assign reg_bit = instr.rr_val[instr.bit_sel];
  assign io_bit = io_rd_data[instr.bit_sel];
  assign flag_bit = sreg[instr.bit_sel];

  // skip when the tested condition holds
  assign skip_hit =
    ((op == aexu_pkg::op_compare_skip_equal)
      && (instr.rd_val == instr.rr_val)) ||
    ((op == aexu_pkg::op_skip_reg_bit_clear) && !reg_bit) ||
    ((op == aexu_pkg::op_skip_reg_bit_set) && reg_bit) ||
    ((op == aexu_pkg::op_skip_io_bit_clear) && !io_bit
      && io_addr_ok) ||
    ((op == aexu_pkg::op_skip_io_bit_set) && io_bit && io_addr_ok);

  assign branch_hit =
    ((op == aexu_pkg::op_branch_flag_set) && flag_bit) ||
    ((op == aexu_pkg::op_branch_flag_clear) && !flag_bit);
  assign branch_offset = {{9{instr.offset[6]}}, instr.offset};

  // --------
  // next flags
  // --------
  logic [7:0] next_sreg;
  logic carry_z;

  // carry variants only keep z when the earlier byte was zero
  assign carry_z = use_carry ? sreg[aexu_pkg::FLAG_Z] : 1'b1;

  // untouched flags fall through from the held value
  always_comb begin
    next_sreg = sreg;
    if (is_arith) begin
      next_sreg[aexu_pkg::FLAG_Z] = is_zero8(arith_res) & carry_z;
      next_sreg[aexu_pkg::FLAG_C] = arith_c;
      next_sreg[aexu_pkg::FLAG_N] = arith_res[7];
      next_sreg[aexu_pkg::FLAG_V] = arith_v;
      next_sreg[aexu_pkg::FLAG_H] = arith_h;
    end else if (is_word) begin
      next_sreg[aexu_pkg::FLAG_Z] = (word_res == 16'h0000);
      next_sreg[aexu_pkg::FLAG_C] = word_c;
      next_sreg[aexu_pkg::FLAG_N] = word_res[15];
      next_sreg[aexu_pkg::FLAG_V] = word_v;
      next_sreg[aexu_pkg::FLAG_S] = word_res[15] ^ word_v;
    end else if (is_logic) begin
      next_sreg[aexu_pkg::FLAG_Z] = is_zero8(logic_res);
      next_sreg[aexu_pkg::FLAG_N] = logic_res[7];
      next_sreg[aexu_pkg::FLAG_V] = 1'b0;
    end
  end

  // --------
  // next program counter, cycles and side effects
  // --------
  logic [15:0] next_pc;
  logic [1:0] next_cycles;
  logic bad_io;

  assign bad_io = (is_io_bit || is_io_skip) && !io_addr_ok;

  // pc and length of the instruction
  always_comb begin
    next_pc = pc + 16'h0001;
    next_cycles = aexu_pkg::CYC_SINGLE;
    if (is_word) begin
      next_cycles = aexu_pkg::CYC_WORD;
    end else if (op == aexu_pkg::op_indirect_jump) begin
      next_pc = instr.z_ptr;
      next_cycles = aexu_pkg::CYC_INDIRECT_JUMP;
    end else if (op == aexu_pkg::op_indirect_call) begin
      next_pc = instr.z_ptr;
      next_cycles = aexu_pkg::CYC_INDIRECT_CALL;
    end else if (skip_hit) begin
      next_pc = instr.next_two_word ? (pc + 16'h0003) : (pc + 16'h0002);
      next_cycles = skip_cycles(instr.next_two_word);
    end else if (branch_hit) begin
      next_pc = pc + branch_offset + 16'h0001;
      next_cycles = aexu_pkg::CYC_BRANCH_TAKEN;
    end else if (is_io_bit && io_addr_ok) begin
      next_cycles = aexu_pkg::CYC_IO_BIT;
    end
  end

  // --------
  // handshake and sequencing
  // --------
  assign instr_ready = (state == st_idle);
  assign take = instr_valid && instr_ready;

  // state and remaining cycle count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_idle;
      count <= 2'h0;
    end else begin
      case (state)
        st_idle: begin
          if (take && (next_cycles != aexu_pkg::CYC_SINGLE)) begin
            state <= st_busy;
            count <= next_cycles - 2'h1;
          end
        end
        st_busy: begin
          count <= count - 2'h1;
          if (count == 2'h1) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // completion pulse on the last cycle of each instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else begin
      done <= (take && (next_cycles == aexu_pkg::CYC_SINGLE))
        || ((state == st_busy) && (count == 2'h1));
    end
  end

  // architectural state updates when an instruction is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sreg <= aexu_pkg::SREG_RESET;
      pc <= aexu_pkg::PC_RESET;
      illegal <= 1'b0;
    end else begin
      illegal <= take && bad_io;
      if (take) begin
        sreg <= next_sreg;
        pc <= next_pc;
      end
    end
  end

  // --------
  // write back, stack push and i/o bit write, one-cycle pulses
  // --------
  logic store_byte;
  logic [7:0] store_data;

  // compares and test leave the register as it was
  assign store_byte = (is_arith && !is_compare)
    || (is_logic && (op != aexu_pkg::op_test_zero_minus));
  assign store_data = is_logic ? logic_res : arith_res;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb <= '0;
      push_en <= 1'b0;
      push_addr <= 16'h0000;
    end else begin
      wb.byte_en <= take && store_byte;
      wb.word_en <= take && is_word;
      push_en <= take && (op == aexu_pkg::op_indirect_call);
      if (take) begin
        wb.byte_data <= store_data;
        wb.word_data <= word_res;
        push_addr <= pc + 16'h0001;
      end
    end
  end

  // one-hot mask keeps other bits, so write-one-to-clear flags survive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_wr <= '0;
    end else begin
      io_wr.en <= take && is_io_bit && io_addr_ok;
      if (take) begin
        io_wr.addr <= instr.io_addr[4:0];
        io_wr.mask <= 8'h01 << instr.bit_sel;
        io_wr.value <= (op == aexu_pkg::op_set_io_bit);
      end
    end
  end

endmodule : aexu_exec

`default_nettype wire

// >>> design/aexu_word_alu.sv
// aexu_word_alu: 16-bit register pair plus or minus a 6-bit constant
// assumes: purely combinational, flags merged by the caller

`timescale 1ns/10ps
`default_nettype none

module aexu_word_alu (
  // operands
  input wire logic [15:0] w,
  input wire logic [5:0] k,
  input wire logic is_sub,
  // result
  output logic [15:0] res,
  output logic ovf,
  output logic carry
);

  // word sum or difference
  assign res = is_sub ? (w - {10'h000, k}) : (w + {10'h000, k});

  // overflow and carry from the high bits only
  assign ovf = is_sub ? (w[15] & ~res[15]) : (~w[15] & res[15]);
  assign carry = is_sub ? (res[15] & ~w[15]) : (~res[15] & w[15]);

endmodule : aexu_word_alu

`default_nettype wire

// >>> shared/aexu_pkg.sv
// aexu_pkg: shared types and constants of the alu / branch execution unit
// assumes: instructions arrive already decoded, one per handshake

package aexu_pkg;

  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [5:0] IO_BIT_ADDR_MAX = 6'h1F;

  // ----------------------------------------------------------------
  // cycle counts per instruction class
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_WORD = 2'h2;
  localparam logic [1:0] CYC_INDIRECT_JUMP = 2'h2;
  localparam logic [1:0] CYC_INDIRECT_CALL = 2'h3;
  localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_IO_BIT = 2'h2;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_add, op_add_carry, op_subtract, op_subtract_immediate,
    op_subtract_with_carry, op_subtract_immediate_with_carry,
    op_word_add_immediate, op_word_subtract_immediate,
    op_and, op_and_immediate, op_or, op_or_immediate,
    op_exclusive_or_registers, op_set_bits_mask, op_clear_bits_mask,
    op_test_zero_minus, op_compare_registers, op_compare_with_carry,
    op_compare_immediate, op_indirect_jump, op_indirect_call,
    op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
    op_skip_io_bit_clear, op_skip_io_bit_set, op_branch_flag_set,
    op_branch_flag_clear, op_set_io_bit, op_clear_io_bit
  } aexu_op_t;

  // one decoded instruction with its operands
  typedef struct packed {
    aexu_op_t op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [15:0] word_val;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic [5:0] io_addr;
    logic [15:0] z_ptr;
    logic next_two_word;
  } aexu_instr_t;

  // register file write back
  typedef struct packed {
    logic byte_en;
    logic [7:0] byte_data;
    logic word_en;
    logic [15:0] word_data;
  } aexu_wb_t;

  // single bit write toward the low i/o range
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] mask;
    logic value;
  } aexu_io_wr_t;

endpackage : aexu_pkg

// >>> sim/aexu_exec_chk.sv
// aexu_exec_chk: cycle, program counter and flag checks at the unit ports
// assumes: bound to aexu_exec, one clock clk, reset arst_n

`timescale 1ns/10ps
`default_nettype none

module aexu_exec_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // handshake
  input wire logic instr_valid,
  input wire aexu_pkg::aexu_instr_t instr,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic illegal,
  // results
  input wire aexu_pkg::aexu_wb_t wb,
  input wire aexu_pkg::aexu_io_wr_t io_wr,
  input wire logic push_en,
  input wire logic [15:0] push_addr,
  input wire logic [7:0] sreg,
  input wire logic [15:0] pc
);
  // ----------------------------------------------------------------
  // accepted instruction decode
  // ----------------------------------------------------------------
  wire logic tk;
  wire logic io_op;
  wire logic [15:0] boff;
  assign tk = instr_valid && instr_ready;
  assign io_op = instr.op inside {aexu_pkg::op_set_io_bit,
    aexu_pkg::op_clear_io_bit};
  assign boff = {{9{instr.offset[6]}}, instr.offset};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  word_two_cyc_a: assert property (
    tk && instr.op inside {aexu_pkg::op_word_add_immediate,
      aexu_pkg::op_word_subtract_immediate}
    |=> !instr_ready && !done ##1 instr_ready && done)
    else $error("word op not two cycles");
  add_one_cyc_a: assert property (
    tk && instr.op == aexu_pkg::op_add |=> done && instr_ready &&
    wb.byte_en && wb.byte_data == $past(instr.rd_val) + $past(instr.rr_val))
    else $error("add result or timing wrong");
  logic_flags_a: assert property (
    tk && instr.op inside {aexu_pkg::op_and, aexu_pkg::op_or,
      aexu_pkg::op_exclusive_or_registers} |=> done && !sreg[3] &&
    sreg[0] == $past(sreg[0]) && sreg[5] == $past(sreg[5]))
    else $error("logic op flags wrong");
  jump_pc_a: assert property (
    tk && instr.op == aexu_pkg::op_indirect_jump |=> !done &&
    pc == $past(instr.z_ptr) && sreg == $past(sreg) ##1 done)
    else $error("indirect jump wrong");
  call_push_a: assert property (
    tk && instr.op == aexu_pkg::op_indirect_call |=> push_en &&
    push_addr == $past(pc) + 16'h0001 && pc == $past(instr.z_ptr)
    ##1 !done ##1 done)
    else $error("indirect call wrong");
  io_bit_wr_a: assert property (
    tk && io_op && instr.io_addr <= 6'h1F |=> io_wr.en && !done &&
    io_wr.mask == 8'h01 << $past(instr.bit_sel) &&
    io_wr.value == ($past(instr.op) == aexu_pkg::op_set_io_bit) &&
    sreg == $past(sreg) ##1 done)
    else $error("io bit write wrong");
  io_range_a: assert property (
    tk && io_op && instr.io_addr > 6'h1F |=> illegal && !io_wr.en &&
    done && pc == $past(pc) + 16'h0001)
    else $error("io address above range not refused");
  br_taken_a: assert property (
    tk && instr.op == aexu_pkg::op_branch_flag_set && sreg[instr.bit_sel]
    |=> pc == $past(pc) + $past(boff) + 16'h0001 && !done ##1 done)
    else $error("taken branch wrong");
  br_not_a: assert property (
    tk && instr.op == aexu_pkg::op_branch_flag_clear && sreg[instr.bit_sel]
    |=> pc == $past(pc) + 16'h0001 && done && sreg == $past(sreg))
    else $error("untaken branch wrong");

  // main scenarios reached
  cover property (tk && instr.op == aexu_pkg::op_indirect_call);
  cover property (tk && instr.op == aexu_pkg::op_skip_io_bit_set);
  cover property (illegal);
endmodule : aexu_exec_chk

bind aexu_exec aexu_exec_chk chk (.clk(clk), .arst_n(arst_n),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
  .done(done), .illegal(illegal), .wb(wb), .io_wr(io_wr),
  .push_en(push_en), .push_addr(push_addr), .sreg(sreg), .pc(pc));

`default_nettype wire

// >>> sim/aexu_exec_test.sv
// aexu_exec_test: directed instruction sequences with expected flags and pc
// assumes: aexu_exec with its checker bound; io reads see a fixed value

`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end

module aexu_exec_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  aexu_pkg::aexu_instr_t instr = '0;
  logic [7:0] io_rd_data = 8'hA5; // fixed i/o register seen by skips
  logic instr_ready, done, illegal, push_en, push1, ill1, tk;
  logic [4:0] io_rd_addr;
  aexu_pkg::aexu_wb_t wb, wb1;
  aexu_pkg::aexu_io_wr_t io_wr, io1;
  logic [15:0] push_addr, pc, pcx;
  logic [7:0] sreg;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  aexu_exec dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .done(done),
    .illegal(illegal), .io_rd_addr(io_rd_addr), .io_rd_data(io_rd_data),
    .wb(wb), .io_wr(io_wr), .push_en(push_en), .push_addr(push_addr),
    .sreg(sreg), .pc(pc));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // fresh instruction with operands, others zero
  task automatic load(input aexu_pkg::aexu_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] k);
    instr = '0;
    instr.op = op;
    instr.rd_val = a;
    instr.rr_val = b;
    instr.imm = k;
  endtask : load

  // offer, capture first-cycle pulses, count cycles to done
  task automatic go(input int n, input logic [15:0] npc,
      input logic [7:0] es);
    int c;
    @(negedge clk);
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    wb1 = wb;
    io1 = io_wr;
    push1 = push_en;
    ill1 = illegal;
    c = 1;
    while (done !== 1'b1 && c < 8) begin
      @(negedge clk);
      c++;
    end
    `CHK("cycles", n, c)
    `CHK("pc", npc, pc)
    `CHK("sreg", es, sreg)
    pcx = npc;
  endtask : go

  task automatic alu(input aexu_pkg::aexu_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] k, input logic [7:0] r,
      input logic [7:0] es);
    load(op, a, b, k);
    go(1, pcx + 16'h0001, es);
    `CHK("result", r, wb1.byte_data)
    `CHK("write", 1'b1, wb1.byte_en)
  endtask : alu

  task automatic sk(input aexu_pkg::aexu_op_t op, input logic [7:0] v,
      input logic [2:0] bs, input logic tw, input logic [5:0] io,
      input int n);
    load(op, v, v, 8'h00);
    instr.bit_sel = bs;
    instr.next_two_word = tw;
    instr.io_addr = io;
    go(n, pcx + 16'(n), 8'h12);
  endtask : sk

  task automatic iob(input aexu_pkg::aexu_op_t op, input logic [5:0] io,
      input logic [2:0] bs, input int n, input aexu_pkg::aexu_io_wr_t ew);
    load(op, 8'h00, 8'h00, 8'h00);
    instr.io_addr = io;
    instr.bit_sel = bs;
    go(n, pcx + 16'h0001, 8'h12);
    `CHK("io write", ew, ew.en ? io1 : {io1.en, ew[13:0]})
    `CHK("illegal", !ew.en, ill1)
  endtask : iob

  task automatic rchk;
    `CHK("pc reset", 16'h0000, pc)
    `CHK("sreg reset", 8'h00, sreg)
    `CHK("ready reset", 1'b1, instr_ready)
  endtask : rchk

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rchk;
    arst_n = 1'b1;
    pcx = 16'h0000;
    alu(aexu_pkg::op_add, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20);
    alu(aexu_pkg::op_add, 8'h80, 8'h80, 8'h00, 8'h00, 8'h0B);
    alu(aexu_pkg::op_subtract_with_carry, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h02);
    alu(aexu_pkg::op_subtract_immediate, 8'h00, 8'h00, 8'h01, 8'hFF,
      8'h25);
    alu(aexu_pkg::op_add_carry, 8'h3F, 8'h40, 8'h00, 8'h80, 8'h2C);
    alu(aexu_pkg::op_subtract_immediate_with_carry, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00);
    alu(aexu_pkg::op_subtract, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h28);
    load(aexu_pkg::op_word_add_immediate, 8'h00, 8'h00, 8'h01);
    instr.word_val = 16'hFFFF;
    go(2, pcx + 16'h0001, 8'h23);
    `CHK("word", 17'h10000, {wb1.word_en, wb1.word_data})
    load(aexu_pkg::op_word_subtract_immediate, 8'h00, 8'h00, 8'hC1);
    instr.word_val = 16'h8000;
    go(2, pcx + 16'h0001, 8'h38);
    `CHK("word", 17'h17FFF, {wb1.word_en, wb1.word_data})
    alu(aexu_pkg::op_and, 8'hF0, 8'h0F, 8'h00, 8'h00, 8'h32);
    alu(aexu_pkg::op_and_immediate, 8'hF0, 8'h00, 8'h30, 8'h30, 8'h30);
    alu(aexu_pkg::op_or, 8'h80, 8'h01, 8'h00, 8'h81, 8'h34);
    alu(aexu_pkg::op_or_immediate, 8'h00, 8'h00, 8'h00, 8'h00, 8'h32);
    alu(aexu_pkg::op_exclusive_or_registers, 8'hFF, 8'hFF, 8'h00, 8'h00,
      8'h32);
    alu(aexu_pkg::op_set_bits_mask, 8'h01, 8'h00, 8'h80, 8'h81, 8'h34);
    alu(aexu_pkg::op_clear_bits_mask, 8'hFF, 8'h00, 8'h0F, 8'hF0, 8'h34);
    load(aexu_pkg::op_test_zero_minus, 8'h00, 8'h00, 8'h00);
    go(1, pcx + 16'h0001, 8'h32);
    load(aexu_pkg::op_compare_registers, 8'h10, 8'h20, 8'h00);
    go(1, pcx + 16'h0001, 8'h15);
    `CHK("no write", 1'b0, wb1.byte_en)
    load(aexu_pkg::op_compare_with_carry, 8'h20, 8'h1F, 8'h00);
    go(1, pcx + 16'h0001, 8'h30);
    load(aexu_pkg::op_compare_immediate, 8'h05, 8'h00, 8'h05);
    go(1, pcx + 16'h0001, 8'h12);
    // every flag with both branch senses, set forward and clear backward
    for (int b = 0; b < 16; b++) begin
      load(b < 8 ? aexu_pkg::op_branch_flag_set
        : aexu_pkg::op_branch_flag_clear, 8'h00, 8'h00, 8'h00);
      instr.bit_sel = b[2:0];
      instr.offset = b[3] ? 7'h7E : 7'h03;
      tk = sreg[b[2:0]] ^ b[3];
      go(tk ? 2 : 1, pcx + 16'h0001 + (tk ? {{9{instr.offset[6]}},
        instr.offset} : 16'h0000), 8'h12);
    end
    sk(aexu_pkg::op_compare_skip_equal, 8'h33, 3'h0, 1'b1, 6'h00, 3);
    sk(aexu_pkg::op_compare_skip_equal, 8'h33, 3'h0, 1'b0, 6'h00, 2);
    load(aexu_pkg::op_compare_skip_equal, 8'h33, 8'h34, 8'h00);
    go(1, pcx + 16'h0001, 8'h12);
    sk(aexu_pkg::op_skip_reg_bit_clear, 8'hFE, 3'h0, 1'b0, 6'h00, 2);
    sk(aexu_pkg::op_skip_reg_bit_set, 8'hFE, 3'h0, 1'b1, 6'h00, 1);
    sk(aexu_pkg::op_skip_reg_bit_set, 8'h80, 3'h7, 1'b1, 6'h00, 3);
    sk(aexu_pkg::op_skip_io_bit_set, 8'h00, 3'h0, 1'b1, 6'h0E, 3);
    sk(aexu_pkg::op_skip_io_bit_clear, 8'h00, 3'h1, 1'b0, 6'h1F, 2);
    sk(aexu_pkg::op_skip_io_bit_clear, 8'h00, 3'h0, 1'b0, 6'h0E, 1);
    sk(aexu_pkg::op_skip_io_bit_set, 8'h00, 3'h0, 1'b1, 6'h20, 1);
    iob(aexu_pkg::op_set_io_bit, 6'h0E, 3'h3, 2,
      {1'b1, 5'h0E, 8'h08, 1'b1});
    iob(aexu_pkg::op_clear_io_bit, 6'h1F, 3'h7, 2,
      {1'b1, 5'h1F, 8'h80, 1'b0});
    iob(aexu_pkg::op_set_io_bit, 6'h20, 3'h0, 1, '0);
    iob(aexu_pkg::op_clear_io_bit, 6'h3F, 3'h2, 1, '0);
    load(aexu_pkg::op_indirect_jump, 8'h00, 8'h00, 8'h00);
    instr.z_ptr = 16'h1234;
    go(2, 16'h1234, 8'h12);
    load(aexu_pkg::op_indirect_call, 8'h00, 8'h00, 8'h00);
    instr.z_ptr = 16'h0100;
    go(3, 16'h0100, 8'h12);
    `CHK("push", 17'h11235, {push1, push_addr})
    // reset again in mid-run
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    rchk;
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    print_verdict;
  end
endmodule : aexu_exec_test

`default_nettype wire
